// file: core/cio_pkg.sv
package cio_pkg;

    // ------------------------------------------------------------------
    // port layout
    // ------------------------------------------------------------------
    localparam int NPORT = 4;
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PIO_BIT = 7;

    typedef logic [NPORT-1:0][7:0] cio_port_t;

    // ------------------------------------------------------------------
    // reset values and implemented-bit masks, index [3] is port d
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam cio_port_t RESET_PORTS = {NPORT{RESET_BYTE}};
    localparam cio_port_t MASK_PINS = {8'h07, 8'hff, 8'hff, 8'hff};
    localparam cio_port_t MASK_MODE = {8'h00, 8'h00, 8'hff, 8'hff};
    localparam cio_port_t MASK_CELL = {8'h00, 8'hff, 8'hff, 8'hff};
    localparam cio_port_t MASK_OPEN = {8'h00, 8'hff, 8'hf0, 8'hf0};
    localparam cio_port_t MASK_SLEW = {8'h07, 8'h00, 8'h0f, 8'h0f};
    localparam cio_port_t MASK_DRIVE = MASK_OPEN | MASK_SLEW;

    // ------------------------------------------------------------------
    // register offsets from the io block base; port index in addr[1:0]
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_PIN_LEVEL_IN = 8'h00;
    localparam logic [7:0] OFF_PIN_LEVEL_OUT = 8'h04;
    localparam logic [7:0] OFF_PIN_MODE_SELECT = 8'h08;
    localparam logic [7:0] OFF_PIN_DIRECTION = 8'h0c;
    localparam logic [7:0] OFF_PIN_DRIVE_SELECT = 8'h10;
    localparam logic [7:0] OFF_OUTPUT_CELL_VALUE = 8'h14;
    localparam logic [7:0] OFF_OUTPUT_CELL_LOAD_BLOCK = 8'h18;
    localparam logic [7:0] OFF_INPUT_CELL_VALUE = 8'h1c;
    localparam logic [7:0] OFF_DRIVER_ENABLE_READBACK = 8'h20;
    localparam logic [7:0] OFF_MEMORY_MAP_CONFIG_REG = 8'h24;

    typedef enum logic [3:0] {
        CIO_NONE,
        CIO_LEVEL_IN,
        CIO_LEVEL_OUT,
        CIO_MODE,
        CIO_DIR,
        CIO_DRIVE,
        CIO_CELL,
        CIO_BLOCK,
        CIO_INCELL,
        CIO_ENABLE,
        CIO_VM
    } cio_kind_e;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } cio_bus_s;

    typedef struct packed {
        cio_port_t level;
        cio_port_t oe;
        cio_port_t open_drain;
        cio_port_t fast_slew;
    } cio_pin_s;

endpackage

// file: core/cio_port_regs.sv
`timescale 1ns/1ns

// Summary of operation
// - memory map config bit 7 turns all of port A into a host data buffer
// - in buffer mode port A floats unless a peripheral select is active with host_to_periph_i set
// - port C pins may be handed to jtag programming, shared with other use
// - bit n of every configuration register except memory map config governs only pin n of its port
// - control, direction and drive select registers clear to zero at reset
// - control register on ports A, B only: 0 general io, 1 latched address
// - direction bit 1 makes the pin an output, 0 input; inputs after reset
// - ports A, B, C drive when direction bit or array enable term is one
// - port D has three pins, only direction bits 2 to 0 exist
// - drive bit 1 gives open drain on A, B bits 7-4 and all of C
// - drive bit 1 gives fast slew on A, B bits 3-0 and D bits 2-0
// - data-in read returns the present level on the port pins
// - data-out stores host writes, drives enabled pins, reads back
// - macrocell read returns its outputs, write loads unmasked flip-flops
// - mask bit one blocks host load of its macrocell, resets to zero
// - input macrocells capture pins, feed the array, host readable
// - enable readback returns each pin's output enable before open-drain release; port D reads zero
// - host reaches registers by plain read and write cycles at offsets
module cio_port_regs (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire cio_pkg::cio_bus_s bus_i,
    output logic [7:0] bus_rdata_o,
    output logic bus_rvalid_o,
    input wire cio_pkg::cio_port_t pin_level_i,
    output cio_pkg::cio_pin_s pins_o,
    input wire cio_pkg::cio_port_t array_oe_i,
    input wire cio_pkg::cio_port_t cell_drive_sel_i,
    input wire cio_pkg::cio_port_t latched_addr_i,
    input wire logic cell_load_i,
    input wire cio_pkg::cio_port_t cell_next_i,
    output cio_pkg::cio_port_t output_cell_o,
    input wire cio_pkg::cio_port_t input_cell_capture_i,
    output cio_pkg::cio_port_t input_cell_o,
    input wire logic peripheral_select_0_i,
    input wire logic peripheral_select_1_i,
    input wire logic host_to_periph_i,
    input wire logic [7:0] host_data_i,
    output logic [7:0] host_data_o,
    input wire logic jtag_enable_i,
    input wire logic [7:0] jtag_pin_sel_i,
    input wire logic [7:0] jtag_out_i,
    input wire logic [7:0] jtag_oe_i,
    output logic [7:0] jtag_in_o
);
    import cio_pkg::*;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic cio_kind_e decode(input logic [7:0] addr);
        cio_kind_e kind;
        kind = CIO_NONE;
        unique case (addr[7:2])
            OFF_PIN_LEVEL_IN[7:2]: kind = CIO_LEVEL_IN;
            OFF_PIN_LEVEL_OUT[7:2]: kind = CIO_LEVEL_OUT;
            OFF_PIN_MODE_SELECT[7:2]: kind = CIO_MODE;
            OFF_PIN_DIRECTION[7:2]: kind = CIO_DIR;
            OFF_PIN_DRIVE_SELECT[7:2]: kind = CIO_DRIVE;
            OFF_OUTPUT_CELL_VALUE[7:2]: kind = CIO_CELL;
            OFF_OUTPUT_CELL_LOAD_BLOCK[7:2]: kind = CIO_BLOCK;
            OFF_INPUT_CELL_VALUE[7:2]: kind = CIO_INCELL;
            OFF_DRIVER_ENABLE_READBACK[7:2]: kind = CIO_ENABLE;
            OFF_MEMORY_MAP_CONFIG_REG[7:2]: kind = CIO_VM;
            default: kind = CIO_NONE;
        endcase
        return kind;
    endfunction

    // bit-wise merge keeps every pin's bit independent
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wdata,
                                         input logic [7:0] mask);
        return (old & ~mask) | (wdata & mask);
    endfunction

    cio_kind_e wr_kind;
    cio_kind_e rd_kind;
    logic [1:0] wr_port;
    logic [1:0] rd_port;
    logic [7:0] wr_byte;

    assign wr_kind = bus_i.wr ? decode(bus_i.addr) : CIO_NONE;
    assign rd_kind = decode(bus_i.addr);
    assign wr_port = bus_i.addr[1:0];
    assign rd_port = bus_i.addr[1:0];
    assign wr_byte = bus_i.wdata;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    cio_port_t pin_mode_select;
    cio_port_t pin_direction;
    cio_port_t pin_drive_select;
    cio_port_t pin_level_out;
    cio_port_t output_cell_load_block;
    logic periph_mode;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_mode_select <= RESET_PORTS;
        end else if (wr_kind == CIO_MODE) begin
            pin_mode_select[wr_port] <= merge(pin_mode_select[wr_port],
                wr_byte, MASK_MODE[wr_port]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_direction <= RESET_PORTS;
        end else if (wr_kind == CIO_DIR) begin
            pin_direction[wr_port] <= merge(pin_direction[wr_port],
                wr_byte, MASK_PINS[wr_port]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_drive_select <= RESET_PORTS;
        end else if (wr_kind == CIO_DRIVE) begin
            pin_drive_select[wr_port] <= merge(pin_drive_select[wr_port],
                wr_byte, MASK_DRIVE[wr_port]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_level_out <= RESET_PORTS;
        end else if (wr_kind == CIO_LEVEL_OUT) begin
            pin_level_out[wr_port] <= merge(pin_level_out[wr_port],
                wr_byte, MASK_PINS[wr_port]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_cell_load_block <= RESET_PORTS;
        end else if (wr_kind == CIO_BLOCK) begin
            output_cell_load_block[wr_port] <= merge(
                output_cell_load_block[wr_port], wr_byte,
                MASK_CELL[wr_port]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            periph_mode <= 1'b0;
        end else if (wr_kind == CIO_VM && wr_port == 2'(PORT_A)) begin
            periph_mode <= wr_byte[PIO_BIT];
        end
    end

    // ------------------------------------------------------------------
    // macrocells
    // ------------------------------------------------------------------
    cio_port_t next_output_cell;

    // host load beats the array load on unmasked bits in the same cycle;
    // blocked bits still follow the array so the logic keeps its state
    always_comb begin
        next_output_cell = output_cell_o;
        for (int p = 0; p < NPORT; p++) begin
            if (cell_load_i) begin
                next_output_cell[p] = merge(next_output_cell[p],
                    cell_next_i[p], MASK_CELL[p]);
            end
            if (wr_kind == CIO_CELL && wr_port == 2'(p)) begin
                next_output_cell[p] = merge(next_output_cell[p], wr_byte,
                    MASK_CELL[p] & ~output_cell_load_block[p]);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_cell_o <= RESET_PORTS;
        end else begin
            output_cell_o <= next_output_cell;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            input_cell_o <= RESET_PORTS;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                input_cell_o[p] <= merge(input_cell_o[p], pin_level_i[p],
                    input_cell_capture_i[p] & MASK_CELL[p]);
            end
        end
    end

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    cio_pin_s next_pins;
    cio_port_t next_enable;
    logic periph_active;

    assign periph_active = peripheral_select_0_i | peripheral_select_1_i;

    always_comb begin
        next_pins = '0;
        next_enable = '0;
        for (int p = 0; p < NPORT; p++) begin
            logic [7:0] oe;
            logic [7:0] val;
            oe = pin_direction[p];
            if (p != PORT_D) begin
                oe = oe | array_oe_i[p];
            end
            val = pin_level_out[p];
            if (p == PORT_A || p == PORT_B) begin
                // software must also set direction for address out
                val = merge(val, latched_addr_i[p], pin_mode_select[p]);
            end
            val = merge(val, output_cell_o[p],
                cell_drive_sel_i[p] & MASK_CELL[p]);
            if (p == PORT_A && periph_mode) begin
                oe = {8{periph_active & host_to_periph_i}};
                val = host_data_i;
            end
            if (p == PORT_C && jtag_enable_i) begin
                oe = merge(oe, jtag_oe_i, jtag_pin_sel_i);
                val = merge(val, jtag_out_i, jtag_pin_sel_i);
            end
            oe = oe & MASK_PINS[p];
            next_enable[p] = oe;
            next_pins.level[p] = val & MASK_PINS[p];
            next_pins.open_drain[p] = pin_drive_select[p] & MASK_OPEN[p];
            next_pins.fast_slew[p] = pin_drive_select[p] & MASK_SLEW[p];
            // an open-drain one releases the pin to the pull-up
            next_pins.oe[p] = oe & ~(next_pins.open_drain[p] & val);
        end
    end

    cio_port_t driver_enable_readback;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_o <= '0;
            driver_enable_readback <= RESET_PORTS;
        end else begin
            pins_o <= next_pins;
            driver_enable_readback <= next_enable;
        end
    end

    // buffer return path toward the host, one sample late
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_data_o <= 8'h00;
            jtag_in_o <= 8'h00;
        end else begin
            host_data_o <= periph_mode ? pin_level_i[PORT_A] : 8'h00;
            jtag_in_o <= pin_level_i[PORT_C] & jtag_pin_sel_i;
        end
    end

    // ------------------------------------------------------------------
    // host read port
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        unique case (rd_kind)
            CIO_LEVEL_IN: next_rdata = pin_level_i[rd_port];
            CIO_LEVEL_OUT: next_rdata = pin_level_out[rd_port];
            CIO_MODE: next_rdata = pin_mode_select[rd_port];
            CIO_DIR: next_rdata = pin_direction[rd_port];
            CIO_DRIVE: next_rdata = pin_drive_select[rd_port];
            CIO_CELL: next_rdata = output_cell_o[rd_port];
            CIO_BLOCK: next_rdata = output_cell_load_block[rd_port];
            CIO_INCELL: next_rdata = input_cell_o[rd_port];
            CIO_ENABLE: next_rdata = driver_enable_readback[rd_port] &
                MASK_CELL[rd_port];
            CIO_VM: next_rdata = (rd_port == 2'(PORT_A)) ?
                {periph_mode, 7'h00} : 8'h00;
            CIO_NONE: next_rdata = 8'h00;
        endcase
        next_rdata = next_rdata & MASK_PINS[rd_port];
        if (rd_kind == CIO_VM) begin
            next_rdata = (rd_port == 2'(PORT_A)) ?
                {periph_mode, 7'h00} : 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_rdata_o <= 8'h00;
            bus_rvalid_o <= 1'b0;
        end else begin
            bus_rvalid_o <= bus_i.rd;
            bus_rdata_o <= bus_i.rd ? next_rdata : 8'h00;
        end
    end

endmodule

// file: verification/cio_pin_model.sv
`timescale 1ns/1ns
module cio_pin_model (
    input wire cio_pkg::cio_pin_s pins_i,
    input wire cio_pkg::cio_port_t ext_val_i,
    input wire cio_pkg::cio_port_t ext_oe_i,
    output cio_pkg::cio_port_t level_o
);
    import cio_pkg::*;

    // board pull-ups on every pin: a released or open-drain high pin
    // reads one rather than a stale level
    assign level_o = (pins_i.oe & pins_i.level)
        | (~pins_i.oe & ext_oe_i & ext_val_i)
        | (~pins_i.oe & ~ext_oe_i);
endmodule

// file: verification/cio_port_regs_assertions.sv
`timescale 1ns/1ns
module cio_port_regs_assertions (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire cio_pkg::cio_bus_s bus_i,
    input wire logic [7:0] bus_rdata_o,
    input wire logic bus_rvalid_o,
    input wire cio_pkg::cio_pin_s pins_o,
    input wire cio_pkg::cio_port_t array_oe_i,
    input wire cio_pkg::cio_port_t pin_level_i,
    input wire cio_pkg::cio_port_t input_cell_capture_i,
    input wire cio_pkg::cio_port_t input_cell_o,
    input wire logic [7:0] jtag_pin_sel_i,
    input wire logic [7:0] jtag_in_o
);
    import cio_pkg::*;

    // ----
    // $past guards skip the edge after reset, which still sees reset values
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_read_answer: assert property ($past(rst_n_i)
        |-> bus_rvalid_o == $past(bus_i.rd)) else $error("read answer late");
    a_idle_data_zero: assert property (!bus_rvalid_o
        |-> bus_rdata_o == 8'h00) else $error("idle read data not zero");
    a_portd_upper_off: assert property (
        pins_o.oe[PORT_D][7:3] == 5'h00) else $error("port d pin driven");
    a_slew_bits_only: assert property (
        (pins_o.fast_slew & ~MASK_SLEW) == '0) else $error("stray slew");
    a_open_bits_only: assert property (
        (pins_o.open_drain & ~MASK_OPEN) == '0) else $error("stray drain");
    a_array_oe_drives: assert property ($past(rst_n_i)
        |-> (~pins_o.oe[PORT_B][3:0] & $past(array_oe_i[PORT_B][3:0]))
        == 4'h0) else $error("array enable ignored");
    a_incell_capture: assert property ($past(rst_n_i)
        |-> ((input_cell_o ^ $past(pin_level_i))
        & $past(input_cell_capture_i) & MASK_CELL) == '0)
        else $error("input cell missed pin");
    a_jtag_levels: assert property ($past(rst_n_i)
        |-> jtag_in_o == ($past(pin_level_i[PORT_C])
        & $past(jtag_pin_sel_i))) else $error("jtag levels wrong");
endmodule

// file: verification/cio_port_regs_tb.sv
`timescale 1ns/1ns
module cio_port_regs_tb;
    import cio_pkg::*;

    logic clk_i;
    logic rst_n_i = 1'b0;
    cio_bus_s bus = '0;
    logic [7:0] rdata, hdo, jin;
    logic rvalid;
    cio_port_t lvl, ocell, icell;
    cio_pin_s pins;
    cio_port_t aoe = '0, laddr = '0, cap = '0, eoe = '0, eval = '0;
    cio_port_t cnext = '0, csel = '0;
    logic cload = 1'b0;
    logic s0 = 1'b0, s1 = 1'b0, h2p = 1'b0, jen = 1'b0;
    logic [7:0] hdi = '0, jsel = '0, jout = '0, joe = '0;
    int error_cnt = 0;
    int checks_done = 0;

    cio_port_regs u_cio_port_regs (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus),
        .bus_rdata_o(rdata), .bus_rvalid_o(rvalid), .pin_level_i(lvl),
        .pins_o(pins), .array_oe_i(aoe), .cell_drive_sel_i(csel),
        .latched_addr_i(laddr), .cell_load_i(cload), .cell_next_i(cnext),
        .output_cell_o(ocell), .input_cell_capture_i(cap),
        .input_cell_o(icell), .peripheral_select_0_i(s0),
        .peripheral_select_1_i(s1), .host_to_periph_i(h2p),
        .host_data_i(hdi), .host_data_o(hdo), .jtag_enable_i(jen),
        .jtag_pin_sel_i(jsel), .jtag_out_i(jout), .jtag_oe_i(joe),
        .jtag_in_o(jin));
    cio_pin_model u_cio_pin_model (.pins_i(pins), .ext_val_i(eval),
        .ext_oe_i(eoe), .level_o(lvl));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        bus.addr = a;
        bus.wdata = d;
        bus.wr = 1'b1;
        @(negedge clk_i);
        bus.wr = 1'b0;
    endtask

    // answer is registered one cycle after the request edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        bus.addr = a;
        bus.rd = 1'b1;
        @(negedge clk_i);
        bus.rd = 1'b0;
        check(32'(rvalid), 32'h1);
        check(32'(rdata), 32'(exp));
    endtask

    // register edge plus the pin register edge
    task automatic settle;
        repeat (2) @(negedge clk_i);
    endtask

    task automatic t_reset;
        for (int p = 0; p < NPORT; p++) begin
            rd(OFF_PIN_DIRECTION + 8'(p), 8'h00);
            rd(OFF_PIN_DRIVE_SELECT + 8'(p), 8'h00);
            rd(OFF_PIN_MODE_SELECT + 8'(p), 8'h00);
            rd(OFF_OUTPUT_CELL_LOAD_BLOCK + 8'(p), 8'h00);
        end
        check(pins.oe, '0);
        rd(8'h3c, 8'h00);
        wr(OFF_PIN_MODE_SELECT + 8'h02, 8'hff);
        rd(OFF_PIN_MODE_SELECT + 8'h02, 8'h00);
        $display("t_reset done");
    endtask

    task automatic t_dir;
        wr(OFF_PIN_DIRECTION + 8'h03, 8'hff);
        rd(OFF_PIN_DIRECTION + 8'h03, 8'h07);
        wr(OFF_PIN_LEVEL_OUT, 8'ha5);
        wr(OFF_PIN_DIRECTION, 8'h0f);
        eoe[PORT_A] = 8'h30;
        eval[PORT_A] = 8'h10;
        settle;
        check(pins.oe[PORT_A], 8'h0f);
        check(pins.level[PORT_A][3:0], 4'h5);
        check(pins.oe[PORT_D], 8'h07);
        rd(OFF_PIN_LEVEL_IN, 8'hd5);
        rd(OFF_PIN_LEVEL_OUT, 8'ha5);
        rd(OFF_DRIVER_ENABLE_READBACK, 8'h0f);
        eoe = '0;
        wr(OFF_PIN_DIRECTION, 8'h00);
        wr(OFF_PIN_DIRECTION + 8'h03, 8'h00);
        aoe[PORT_B] = 8'h3c;
        aoe[PORT_D] = 8'hff;
        wr(OFF_PIN_DIRECTION + 8'h01, 8'h01);
        settle;
        check(pins.oe[PORT_B], 8'h3d);
        check(pins.oe[PORT_D], 8'h00);
        rd(OFF_DRIVER_ENABLE_READBACK + 8'h01, 8'h3d);
        aoe = '0;
        wr(OFF_PIN_DIRECTION + 8'h01, 8'h00);
        $display("t_dir done");
    endtask

    task automatic t_drive;
        for (int p = 0; p < NPORT; p++) begin
            wr(OFF_PIN_DRIVE_SELECT + 8'(p), 8'hff);
        end
        wr(OFF_PIN_LEVEL_OUT + 8'h02, 8'h0f);
        wr(OFF_PIN_DIRECTION + 8'h02, 8'hff);
        settle;
        check(pins.open_drain, MASK_OPEN);
        check(pins.fast_slew, MASK_SLEW);
        check(pins.oe[PORT_C], 8'hf0);
        rd(OFF_PIN_LEVEL_IN + 8'h02, 8'h0f);
        rd(OFF_DRIVER_ENABLE_READBACK + 8'h02, 8'hff);
        rd(OFF_PIN_DRIVE_SELECT + 8'h03, 8'h07);
        for (int p = 0; p < NPORT; p++) begin
            wr(OFF_PIN_DRIVE_SELECT + 8'(p), 8'h00);
        end
        wr(OFF_PIN_DIRECTION + 8'h02, 8'h00);
        $display("t_drive done");
    endtask

    task automatic t_cell;
        wr(OFF_OUTPUT_CELL_LOAD_BLOCK, 8'h0f);
        wr(OFF_OUTPUT_CELL_VALUE, 8'hff);
        rd(OFF_OUTPUT_CELL_VALUE, 8'hf0);
        rd(OFF_OUTPUT_CELL_LOAD_BLOCK, 8'h0f);
        rd(OFF_OUTPUT_CELL_VALUE + 8'h03, 8'h00);
        check(ocell[PORT_A], 8'hf0);
        cap[PORT_A] = 8'hff;
        settle;
        cap = '0;
        rd(OFF_INPUT_CELL_VALUE, 8'hff);
        rd(OFF_INPUT_CELL_VALUE + 8'h03, 8'h00);
        wr(OFF_OUTPUT_CELL_LOAD_BLOCK, 8'h00);
        $display("t_cell done");
    endtask

    // array loads pass the host mask; a host write in the same cycle wins on unblocked bits
    task automatic t_array;
        wr(OFF_OUTPUT_CELL_LOAD_BLOCK, 8'h0f);
        cnext[PORT_A] = 8'h3c;
        cnext[PORT_D] = 8'hff;
        cload = 1'b1;
        @(negedge clk_i);
        check(ocell[PORT_A], 8'h3c);
        check(ocell[PORT_D], 8'h00);
        cnext = '0;
        wr(OFF_OUTPUT_CELL_VALUE, 8'ha5);
        cload = 1'b0;
        rd(OFF_OUTPUT_CELL_VALUE, 8'ha0);
        csel[PORT_B] = 8'hff;
        wr(OFF_OUTPUT_CELL_VALUE + 8'h01, 8'h69);
        wr(OFF_PIN_DIRECTION + 8'h01, 8'hff);
        settle;
        check(pins.level[PORT_B], 8'h69);
        csel = '0;
        wr(OFF_PIN_DIRECTION + 8'h01, 8'h00);
        wr(OFF_OUTPUT_CELL_LOAD_BLOCK, 8'h00);
        $display("t_array done");
    endtask

    task automatic t_buffer;
        wr(OFF_MEMORY_MAP_CONFIG_REG, 8'hff);
        rd(OFF_MEMORY_MAP_CONFIG_REG, 8'h80);
        h2p = 1'b1;
        hdi = 8'h3c;
        settle;
        check(pins.oe[PORT_A], 8'h00);
        s0 = 1'b1;
        settle;
        check(pins.oe[PORT_A], 8'hff);
        check(pins.level[PORT_A], 8'h3c);
        h2p = 1'b0;
        eoe[PORT_A] = 8'hff;
        eval[PORT_A] = 8'h96;
        settle;
        check(hdo, 8'h96);
        s0 = 1'b0;
        s1 = 1'b1;
        h2p = 1'b1;
        eoe = '0;
        settle;
        check(pins.oe[PORT_A], 8'hff);
        s1 = 1'b0;
        settle;
        check(pins.oe[PORT_A], 8'h00);
        wr(OFF_MEMORY_MAP_CONFIG_REG, 8'h00);
        h2p = 1'b0;
        $display("t_buffer done");
    endtask

    task automatic t_share;
        jen = 1'b1;
        jsel = 8'h0f;
        jout = 8'h05;
        joe = 8'h0f;
        settle;
        check(pins.oe[PORT_C][3:0], 4'hf);
        check(pins.level[PORT_C][3:0], 4'h5);
        check(jin, 8'h05);
        jen = 1'b0;
        laddr[PORT_A] = 8'h5a;
        wr(OFF_PIN_DIRECTION, 8'hff);
        wr(OFF_PIN_MODE_SELECT, 8'hff);
        rd(OFF_PIN_MODE_SELECT, 8'hff);
        settle;
        check(pins.oe[PORT_C], 8'h00);
        check(pins.level[PORT_A], 8'h5a);
        wr(OFF_PIN_MODE_SELECT, 8'h00);
        settle;
        check(pins.level[PORT_A], 8'ha5);
        $display("t_share done");
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        t_reset;
        t_dir;
        t_drive;
        t_cell;
        t_array;
        t_buffer;
        t_share;
        give_verdict;
    end

    // the sequence needs well under two thousand cycles
    initial begin
        #40000;
        error_cnt++;
        give_verdict;
    end
endmodule

bind cio_port_regs cio_port_regs_assertions u_cio_port_regs_assertions (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o),
    .pins_o(pins_o), .array_oe_i(array_oe_i), .pin_level_i(pin_level_i),
    .input_cell_capture_i(input_cell_capture_i),
    .input_cell_o(input_cell_o), .jtag_pin_sel_i(jtag_pin_sel_i),
    .jtag_in_o(jtag_in_o));
